// ===== level_gain_chk.sv
// Port checker for the level-control gain stage.
// Assumes one clock domain; nrst low disables every check.
`timescale 1ns/1ns
module level_gain_chk (
    input wire logic                  core_clk,
    input wire logic                  nrst,
    input wire logic                  fs_tick,
    input wire logic [7:0]            alc_gain,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic                  avs_waitrequest,
    input wire level_gain_pkg::pair_s applied_gain,
    input wire logic                  alc_run,
    input wire logic                  manual_mode,
    input wire logic                  soft_mute_out
);
    import level_gain_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_ack_next;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("no answer one cycle after request");
    property p_ack_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("answer held too long");
    property p_idle_wait;
        !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("answer without request");
    property p_alc_take;
        alc_run && fs_tick |=> applied_gain == {2{$past(alc_gain)}};
    endproperty
    a_alc_take: assert property (p_alc_take)
        else $error("working gain not applied");
    property p_alc_hold;
        alc_run && !fs_tick |=> $stable(applied_gain);
    endproperty
    a_alc_hold: assert property (p_alc_hold) else $error("gain moved between samples");
    property p_mute_alc;
        alc_run |-> !soft_mute_out;
    endproperty
    a_mute_alc: assert property (p_mute_alc)
        else $error("soft mute active in level control");
    property p_excl;
        !(alc_run && manual_mode);
    endproperty
    a_excl: assert property (p_excl) else $error("manual and level control together");
    property p_release;
        $fell(alc_run) |-> !manual_mode;
    endproperty
    a_release: assert property (p_release) else $error("manual before release ramp");
    property p_ramp_step;
        !alc_run && !manual_mode |=>
            (applied_gain.left - $past(applied_gain.left)) inside {8'h00, 8'h01, 8'hFF};
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("release ramp jumped");

    c_alc_tick: cover property (alc_run && fs_tick);
    c_rel_tick: cover property (!alc_run && !manual_mode && fs_tick);
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind level_gain_ctrl level_gain_chk level_gain_chk_i (
    .core_clk(core_clk), .nrst(nrst), .fs_tick(fs_tick), .alc_gain(alc_gain),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .applied_gain(applied_gain), .alc_run(alc_run), .manual_mode(manual_mode),
    .soft_mute_out(soft_mute_out));

// ===== level_gain_ctrl.sv
// Level-control gain stage: register file, mode control, soft ramp, readback.
// Assumes fs_tick and alc_gain come from logic on core_clk; the limiter
// engine itself sits outside and follows the tuning outputs.
//
// What this block does
// - While level control runs, readback shows the gain being applied.
// - Readback is binned in 1.5 dB steps from 21H to EDH, codes step by four, coarser below 21H, 0 is mute.
// - After disable, gain ramps to manual value; manual mode when ramp ends.
// - Input volume is manual when level control off and record path chosen.
// - Input codes: F1H is +36 dB, 0.375 dB steps, 00H mute, E1H default.
// - Code changes ramp softly, one code step every RAMP_INTERVAL sample periods.
// - Link bit 0: separate channels; link bit 1: left field drives both.
// - Writes while filter is off are held and used once it powers up.
// - Path change swaps the active value between input and output fields.
// - Level control runs only when enabled, on the selected path.
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
module level_gain_ctrl (
    input  wire logic                           core_clk,
    input  wire logic                           nrst,
    input  wire logic                           clk_en,
    input  wire logic                           fs_tick,
    input  wire logic [7:0]                     alc_gain,
    input  wire logic [level_gain_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                           avs_read,
    input  wire logic                           avs_write,
    input  wire logic [31:0]                    avs_writedata,
    input  wire logic [3:0]                     avs_byteenable,
    output logic      [31:0]                    avs_readdata,
    output logic                                avs_waitrequest,
    output level_gain_pkg::pair_s               applied_gain,
    output level_gain_pkg::tune_s               alc_tune,
    output logic      [7:0]                     alc_ceiling,
    output logic                                alc_run,
    output logic                                alc_record,
    output logic                                manual_mode,
    output logic                                soft_mute_out
);
    import level_gain_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] rb_bin(input logic [7:0] g);
        logic [7:0] m;
        logic [7:0] r;
        m = g - GAIN_ONE;
        if (g == GAIN_MUTE) begin
            r = GAIN_MUTE;
        end else if (g >= RB_TOP) begin
            r = RB_TOP;
        end else if (g >= RB_FINE_LO) begin
            r = {m[7:2], 2'b00} + GAIN_ONE;
        end else if (g >= RB_MID) begin
            r = RB_MID;
        end else if (g >= RB_LOW) begin
            r = RB_LOW;
        end else begin
            r = GAIN_ONE;
        end
        return r;
    endfunction

    function automatic logic [7:0] step_to(input logic [7:0] cur,
                                           input logic [7:0] tgt);
        logic [7:0] r;
        r = cur;
        if (cur < tgt) begin
            r = cur + GAIN_ONE;
        end else if (cur > tgt) begin
            r = cur - GAIN_ONE;
        end
        return r;
    endfunction

    // Reset release synchroniser
    logic [1:0] rs_q;
    logic       rst_n;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rs_q <= 2'b00;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    assign rst_n = rs_q[1];

    // Register file and bus state
    ctrl_s       ctrl_q,  ctrl_d;
    pair_s       in_q,    in_d;
    pair_s       out_q,   out_d;
    tune_s       tune_q,  tune_d;
    logic [7:0]  rceil_q, rceil_d;
    logic [7:0]  pceil_q, pceil_d;
    logic        wq_q,    wq_d;
    logic [31:0] rdat_q,  rdat_d;

    // Gain engine state
    mode_e       mode_q,  mode_d;
    pair_s       gain_q,  gain_d;
    logic [7:0]  rb_q,    rb_d;
    logic        path_q,  path_d;
    logic [RCNT_W-1:0] rcnt_q, rcnt_d;
    logic [7:0]  ceil_q,  ceil_d;
    logic        rec_q,   rec_d;
    logic        soft_mute_request_q, soft_mute_request_d;

    logic        busy;
    pair_s       tgt;

    assign busy = (gain_q != tgt);

    always_comb begin
        logic [31:0] w;
        w       = 32'h0000_0000;
        ctrl_d  = ctrl_q;
        in_d    = in_q;
        out_d   = out_q;
        tune_d  = tune_q;
        rceil_d = rceil_q;
        pceil_d = pceil_q;
        rdat_d  = rdat_q;
        // One wait cycle per access; answer lands in the following cycle
        wq_d    = ~((avs_read | avs_write) & wq_q);
        if (avs_read && wq_q) begin
            case (avs_address)
                OFF_CTRL: rdat_d = 32'(ctrl_q);
                OFF_IN:   rdat_d = 32'(in_q);
                OFF_OUT:  rdat_d = 32'(out_q);
                OFF_TUNE: rdat_d = 32'(tune_q);
                OFF_CEIL: rdat_d = 32'({pceil_q, rceil_q});
                OFF_STAT: rdat_d = 32'({mode_q == M_ALC, busy,
                                        mode_q == M_MANUAL, rb_q});
                default:  rdat_d = 32'h0000_0000;
            endcase
        end
        if (avs_write && !wq_q) begin
            case (avs_address)
                OFF_CTRL: begin
                    w = merge(32'(ctrl_q), avs_writedata, avs_byteenable);
                    ctrl_d = ctrl_s'(w[CTRL_W-1:0]);
                end
                OFF_IN: begin
                    // Held even with the filter off, used when it powers up
                    w = merge(32'(in_q), avs_writedata, avs_byteenable);
                    in_d = pair_s'(w[PAIR_W-1:0]);
                end
                OFF_OUT: begin
                    w = merge(32'(out_q), avs_writedata, avs_byteenable);
                    out_d = pair_s'(w[PAIR_W-1:0]);
                end
                OFF_TUNE: begin
                    // Not locked: software must disable level control first
                    w = merge(32'(tune_q), avs_writedata, avs_byteenable);
                    tune_d = tune_s'(w[TUNE_W-1:0]);
                end
                OFF_CEIL: begin
                    w = merge(32'({pceil_q, rceil_q}), avs_writedata,
                              avs_byteenable);
                    rceil_d = w[7:0];
                    pceil_d = w[15:8];
                end
                default: begin
                    w = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q  <= '0;
            in_q    <= '{right: RST_IN_GAIN, left: RST_IN_GAIN};
            out_q   <= '{right: RST_OUT_GAIN, left: RST_OUT_GAIN};
            tune_q  <= '0;
            rceil_q <= RST_CEIL;
            pceil_q <= RST_CEIL;
            wq_q    <= 1'b1;
            rdat_q  <= 32'h0000_0000;
        end else if (clk_en) begin
            ctrl_q  <= ctrl_d;
            in_q    <= in_d;
            out_q   <= out_d;
            tune_q  <= tune_d;
            rceil_q <= rceil_d;
            pceil_q <= pceil_d;
            wq_q    <= wq_d;
            rdat_q  <= rdat_d;
        end
    end

    always_comb begin
        pair_s src;
        logic  lnk;
        src = ctrl_q.record_path_select ? in_q : out_q;
        lnk = ctrl_q.record_path_select ? ctrl_q.input_gain_link
                                        : ctrl_q.output_gain_link;
        tgt.left  = src.left;
        tgt.right = lnk ? src.left : src.right;
    end

    always_comb begin
        mode_d  = mode_q;
        gain_d  = gain_q;
        rcnt_d  = rcnt_q;
        rb_d    = rb_q;
        path_d  = path_q;
        rec_d   = ctrl_q.record_path_select;
        ceil_d  = ctrl_q.record_path_select ? rceil_q : pceil_q;
        case (mode_q)
            M_MANUAL: begin
                if (ctrl_q.auto_level_enable) begin
                    mode_d = M_ALC;
                end
            end
            M_ALC: begin
                if (!ctrl_q.auto_level_enable) begin
                    mode_d = M_RELEASE;
                end
            end
            M_RELEASE: begin
                if (ctrl_q.auto_level_enable) begin
                    mode_d = M_ALC;
                end else if (!busy) begin
                    mode_d = M_MANUAL;
                end
            end
            default: begin
                mode_d = M_MANUAL;
            end
        endcase
        // Soft mute has no effect while level control owns the gain;
        // taken from the next mode so it never overlaps a level-control cycle
        soft_mute_request_d = ctrl_q.soft_mute_request & (mode_d != M_ALC);
        if (mode_q == M_ALC) begin
            rcnt_d = RAMP_RELOAD;
            if (fs_tick) begin
                gain_d = '{right: alc_gain, left: alc_gain};
            end
        end else if (ctrl_q.filter_power_on) begin
            path_d = ctrl_q.record_path_select;
            if (path_q != ctrl_q.record_path_select
                && mode_q == M_MANUAL) begin
                // Abrupt swap; soft mute beforehand hides the step
                gain_d = tgt;
            end else if (fs_tick) begin
                if (rcnt_q == '0) begin
                    rcnt_d       = RAMP_RELOAD;
                    gain_d.left  = step_to(gain_q.left, tgt.left);
                    gain_d.right = step_to(gain_q.right, tgt.right);
                end else begin
                    rcnt_d = rcnt_q - 1'b1;
                end
            end
        end
        if (fs_tick) begin
            rb_d = rb_bin(gain_q.left);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q  <= M_MANUAL;
            gain_q  <= '{right: RST_OUT_GAIN, left: RST_OUT_GAIN};
            rcnt_q  <= RAMP_RELOAD;
            rb_q    <= RST_OUT_GAIN;
            path_q  <= 1'b0;
            ceil_q  <= RST_CEIL;
            rec_q   <= 1'b0;
            soft_mute_request_q <= 1'b0;
        end else if (clk_en) begin
            mode_q  <= mode_d;
            gain_q  <= gain_d;
            rcnt_q  <= rcnt_d;
            rb_q    <= rb_d;
            path_q  <= path_d;
            ceil_q  <= ceil_d;
            rec_q   <= rec_d;
            soft_mute_request_q <= soft_mute_request_d;
        end
    end

    assign avs_readdata    = rdat_q;
    assign avs_waitrequest = wq_q;
    assign applied_gain    = gain_q;
    assign alc_tune        = tune_q;
    assign alc_ceiling     = ceil_q;
    assign alc_run         = mode_q[1];
    assign alc_record      = rec_q;
    assign manual_mode     = mode_q[0];
    assign soft_mute_out   = soft_mute_request_q;

endmodule

// ===== level_gain_pkg.sv
// Constants, field layouts and modes for the level-control gain stage.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
package level_gain_pkg;

    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFF_CTRL  = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_IN    = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_OUT   = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_TUNE  = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_CEIL  = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_STAT  = 5'h14;

    localparam logic [7:0] RST_IN_GAIN  = 8'hE1;
    localparam logic [7:0] RST_OUT_GAIN = 8'h91;
    localparam logic [7:0] RST_CEIL     = 8'hE1;
    localparam logic [7:0] GAIN_MUTE    = 8'h00;
    localparam logic [7:0] GAIN_ONE     = 8'h01;
    localparam logic [7:0] RB_TOP       = 8'hED;
    localparam logic [7:0] RB_FINE_LO   = 8'h21;
    localparam logic [7:0] RB_MID       = 8'h19;
    localparam logic [7:0] RB_LOW       = 8'h11;

    // Soft transition budget, counted in sample periods so it scales with fs
    localparam int SOFT_TIME_US  = 10000;
    localparam int REF_FS_HZ     = 44100;
    localparam int TRANS_SAMPLES = SOFT_TIME_US * REF_FS_HZ / 1000000;
    localparam int CODE_SPAN     = 241;
    localparam int RAMP_INTERVAL = (TRANS_SAMPLES / CODE_SPAN < 1) ? 1
                                 : TRANS_SAMPLES / CODE_SPAN;
    localparam int RCNT_W        = 8;
    localparam logic [RCNT_W-1:0] RAMP_RELOAD = RCNT_W'(RAMP_INTERVAL - 1);

    typedef struct packed {
        logic soft_mute_request;
        logic filter_power_on;
        logic output_gain_link;
        logic input_gain_link;
        logic record_path_select;
        logic auto_level_enable;
    } ctrl_s;
    localparam int CTRL_W = $bits(ctrl_s);

    typedef struct packed {
        logic [1:0] fast_recovery_step_sel;
        logic [2:0] recovery_step_sel;
        logic [1:0] recovery_wait_sel;
        logic [1:0] limiter_threshold_sel;
    } tune_s;
    localparam int TUNE_W = $bits(tune_s);

    typedef struct packed {
        logic [7:0] right;
        logic [7:0] left;
    } pair_s;
    localparam int PAIR_W = $bits(pair_s);

    typedef enum logic [2:0] {
        M_MANUAL  = 3'b001,
        M_ALC     = 3'b010,
        M_RELEASE = 3'b100
    } mode_e;

endpackage

// ===== tb.sv
// Self-checking bench for the level-control gain stage.
// Assumes the checker is bound in; the bench plays host and limiter engine.
`timescale 1ns/1ns
module tb;
    import level_gain_pkg::*;
    logic              core_clk = 1'b0;
    logic              nrst = 1'b0;
    logic              fs_tick = 1'b0;
    logic [7:0]        alc_gain = 8'h00;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [31:0]       avs_writedata = 32'h0;
    logic [3:0]        avs_byteenable = 4'hF;
    logic              clk_en = 1'b1;
    logic [31:0]       avs_readdata, rdq;
    logic              avs_waitrequest, alc_run, alc_record, manual_mode, soft_mute_out;
    pair_s             applied_gain;
    tune_s             alc_tune;
    logic [7:0]        alc_ceiling;
    logic [7:0]        mg[2];
    logic [7:0]        tg[2];
    logic [7:0]        codes[$];
    logic [8:0]        tune;
    int                errors = 0;
    int                cmp_count = 0;
    int                cyc = 0;

    level_gain_ctrl level_gain_ctrl_i (
        .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .fs_tick(fs_tick),
        .alc_gain(alc_gain), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .applied_gain(applied_gain),
        .alc_tune(alc_tune), .alc_ceiling(alc_ceiling), .alc_run(alc_run),
        .alc_record(alc_record), .manual_mode(manual_mode), .soft_mute_out(soft_mute_out));

    always #25 core_clk = ~core_clk;

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Whole run needs a few thousand cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rdq = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        cmp(32'(n), 32'h2);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        cmp(rdq, exp);
    endtask

    task automatic tick;
        @(posedge core_clk);
        fs_tick <= 1'b1;
        @(posedge core_clk);
        fs_tick <= 1'b0;
        @(posedge core_clk);
    endtask

    // Model: one code per sample toward the target, per channel
    task automatic rtick;
        tick();
        for (int c = 0; c < 2; c++) begin
            if (mg[c] < tg[c])
                mg[c]++;
            else if (mg[c] > tg[c])
                mg[c]--;
        end
        cmp({16'h0, applied_gain}, {16'h0, mg[1], mg[0]});
    endtask

    task automatic ramp(input logic rel);
        int n;
        n = 0;
        while ((mg[0] !== tg[0] || mg[1] !== tg[1]) && n < 300) begin
            if (rel)
                cmp({31'h0, manual_mode}, 32'h0);
            rtick();
            n++;
        end
        rtick();
    endtask

    function automatic logic [7:0] rbin(input logic [7:0] g);
        if (g == 8'h00)
            return 8'h00;
        if (g < 8'h11)
            return 8'h01;
        if (g < 8'h19)
            return 8'h11;
        if (g < 8'h21)
            return 8'h19;
        if (g >= 8'hED)
            return 8'hED;
        return ((g - 8'h01) & 8'hFC) + 8'h01;
    endfunction

    initial begin
        rdq = $urandom(83);
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        cmp({16'h0, applied_gain}, 32'h0000_9191);
        rd(OFF_CTRL, 32'h0);
        rd(OFF_IN, 32'h0000_E1E1);
        rd(OFF_CEIL, 32'h0000_E1E1);
        wr(OFF_STAT, 32'hFFFF_FFFF);
        rd(OFF_STAT, 32'h0000_0191);
        wr(5'h18, $urandom);
        rd(5'h18, 32'h0);
        tune = 9'($urandom);
        wr(OFF_TUNE, {23'h0, tune});
        rd(OFF_TUNE, {23'h0, tune});
        wr(OFF_CEIL, 32'h0000_A1C5);
        bus(1'b1, OFF_OUT, 32'h0000_5A5A, 4'h1);
        rd(OFF_OUT, 32'h0000_915A);
        // Record path, manual, both ends of the code range
        wr(OFF_CTRL, 32'h12);
        repeat (2) @(posedge core_clk);
        mg = '{8'hE1, 8'hE1};
        cmp({16'h0, applied_gain}, 32'h0000_E1E1);
        cmp({31'h0, manual_mode}, 32'h1);
        tg = '{8'hF1, 8'h00};
        wr(OFF_IN, {16'h0, tg[1], tg[0]});
        // Clock enable low: sample ticks must not move the gain
        clk_en <= 1'b0;
        repeat (2) tick();
        cmp({16'h0, applied_gain}, 32'h0000_E1E1);
        clk_en <= 1'b1;
        ramp(1'b0);
        tg[0] = 8'h30 + 8'($urandom_range(0, 7));
        tg[1] = tg[0];
        wr(OFF_CTRL, 32'h16);
        wr(OFF_IN, {16'h0, 8'h10, tg[0]});
        ramp(1'b0);
        // Filter off: writes held, gain frozen
        wr(OFF_CTRL, 32'h06);
        wr(OFF_IN, 32'h0000_3838);
        repeat (3) rtick();
        tg = '{8'h38, 8'h38};
        wr(OFF_CTRL, 32'h16);
        ramp(1'b0);
        // Level control on the record path
        wr(OFF_CTRL, 32'h33);
        repeat (2) @(posedge core_clk);
        cmp({29'h0, alc_run, manual_mode, soft_mute_out}, 32'h4);
        cmp({7'h0, alc_record, alc_ceiling, 7'h0, alc_tune}, {7'h1, 8'hC5, 7'h0, tune});
        codes = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h18, 8'h19, 8'h20, 8'h21, 8'h24, 8'h91,
                  8'h94, 8'h95, 8'hEC, 8'hED, 8'hF0};
        repeat (4) codes.push_back(8'($urandom_range(1, 240)));
        foreach (codes[i]) begin
            alc_gain <= codes[i];
            tick();
            cmp({16'h0, applied_gain}, {16'h0, codes[i], codes[i]});
            tick();
            bus(1'b0, OFF_STAT, 32'h0, 4'hF);
            cmp(rdq & 32'hFFFF_FDFF, {21'h0, 3'b100, rbin(codes[i])});
        end
        // Disable: ramp back to the manual setting first
        mg = '{codes[$], codes[$]};
        wr(OFF_CTRL, 32'h12);
        ramp(1'b1);
        repeat (2) @(posedge core_clk);
        cmp({31'h0, manual_mode}, 32'h1);
        // Mute first, then swap to the playback path
        wr(OFF_CTRL, 32'h32);
        wr(OFF_CTRL, 32'h30);
        repeat (2) @(posedge core_clk);
        cmp({15'h0, alc_record, applied_gain}, 32'h0000_915A);
        cmp({31'h0, soft_mute_out}, 32'h1);
        // Output link: left playback field drives both channels
        wr(OFF_CTRL, 32'h38);
        mg = '{8'h5A, 8'h91};
        tg = '{8'h5A, 8'h5A};
        ramp(1'b0);
        wr(OFF_CTRL, 32'h11);
        repeat (2) @(posedge core_clk);
        cmp({24'h0, alc_ceiling}, 32'h0000_00A1);
        final_report();
    end
endmodule
